// *** rtl/ihcs_top.sv ***
/*
  Host and client status/flow logic of a two-wire serial controller,
  with an APB register slave.
  Assumes open-drain pins resolved outside, pull-ups on both lines,
  and a bus clock far slower than ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ihcs_map.svh"

// What this block does
// (R1) Write address acked: write flag, ack clear, hold
// (R2) Clock hold keeps SCL low
// (R3) Read address acked: clear ack, receive
// (R4) Address refused: write and ack flags set
// (R5) Software then stops or resends address
// (R6) Arbitration lost: flags, release lines, Busy
// (R7) Bus error also sets bus error flag
// (R8) Data write clears write flag, sets at end
// (R9) Collision during data loses arbitration
// (R10) Ack flag reflects client ack of data
// (R11) Ack flag valid only without errors
// (R12) Read one byte, then read flag and hold
// (R13) Command sends chosen ack or nack
// (R14) Lost nack sets write, arbitration, Busy
// (R15) Read and write flags never both set, except a bus error on the last read bit
// (R16) Client flag set holds SCL low
// (R17) Client acks and stores matching address
// (R18) Client address match: four ways
// (R19) Start then Stop: client bus error
// (R20) Client write direction holds clock
// (R21) Four-value bus state, readable
// (R22) Address write copies to data, starts
// (R23) Clearing host flags releases clock hold
module ihcs_top import ihcs_pkg::*; #(
  parameter int HALF_CYC = `IHCS_HALF_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Two-wire bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  // ============================================================
  // Timing constants
  localparam logic [15:0] HALF_M1 = 16'(HALF_CYC - 1);
  localparam logic [15:0] QTR = 16'(HALF_CYC / 2);

  // ============================================================
  // Pin synchronisers and condition detectors
  logic scl_m, scl_s, scl_d; // Sync stages and delayed copy
  logic sda_m, sda_s, sda_d;
  // Lines idle high, so reset to high
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
    end
  end
  wire logic start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire logic stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire logic scl_rise = scl_s & ~scl_d;
  wire logic scl_fall = ~scl_s & scl_d;

  // ============================================================
  // Register decode
  logic [2:0] ctrl_r; // Enables and promiscuous bit
  logic ack_action_bit_r; // 0 ack, 1 nack
  logic [7:0] haddr_r, caddr_r, cmask_r, cdata_r;
  logic [31:0] prdata_r;
  ihcs_hflags_s hf_r;
  ihcs_bus_e bus_r;
  ihcs_hs_e hs_r, hs_nxt;
  wire logic acc = psel & penable;
  wire logic wr = acc & pwrite;
  wire logic s_ctrl = paddr == `IHCS_CTRL_OFS;
  wire logic s_hcmd = paddr == `IHCS_HCMD_OFS;
  wire logic s_hst = paddr == `IHCS_HSTAT_OFS;
  wire logic s_hadr = paddr == `IHCS_HADDR_OFS;
  wire logic s_hdat = paddr == `IHCS_HDATA_OFS;
  wire logic s_cadr = paddr == `IHCS_CADDR_OFS;
  wire logic s_cmsk = paddr == `IHCS_CMASK_OFS;
  wire logic s_cst = paddr == `IHCS_CSTAT_OFS;
  wire logic s_cdat = paddr == `IHCS_CDATA_OFS;
  wire logic hit = s_ctrl | s_hcmd | s_hst | s_hadr | s_hdat | s_cadr |
                   s_cmsk | s_cst | s_cdat;
  wire logic w_hcmd = wr & s_hcmd;
  wire logic w_hadr = wr & s_hadr;
  wire logic w_hdat = wr & s_hdat;
  wire logic w_hst = wr & s_hst;
  wire logic w_cst = wr & s_cst;
  wire logic host_en = ctrl_r[`IHCS_HEN_BIT];
  wire logic cli_en = ctrl_r[`IHCS_CEN_BIT];
  wire ihcs_cmd_e cmd_w = ihcs_cmd_e'(pwdata[1:0]);
  wire logic cmd_go = w_hcmd & (cmd_w != CMD_NOACT);
  // Write-one-to-clear strobes and the force-Idle write
  wire logic clr_rif = w_hst & pwdata[`IHCS_RIF_BIT];
  wire logic clr_wif = w_hst & pwdata[`IHCS_WIF_BIT];
  wire logic clr_arb = w_hst & pwdata[`IHCS_ARB_BIT];
  wire logic clr_berr = w_hst & pwdata[`IHCS_BERR_BIT];
  wire logic force_idle = w_hst & (pwdata[1:0] == BS_IDLE);

  // ============================================================
  // Host engine
  logic [15:0] cnt_r, cnt_nxt; // Half-period timer
  logic [3:0] bit_r, bit_nxt; // 0..7 data, 8 ack slot
  logic [7:0] sh_r, sh_nxt; // Host data register and shifter
  logic sda_lo_r, sda_lo_nxt; // Host pulls SDA low
  logic rd_r, rd_nxt, isad_r, isad_nxt, acko_r, acko_nxt;
  logic ph_r, ph_nxt, gost_r, gost_nxt, pend_r, pend_nxt;
  ihcs_cmd_e pcmd_r, pcmd_nxt;
  logic e_wack, e_rack, e_nack, e_dtx, e_rif, e_lose, e_own;
  // Bus error: a condition in the middle of our own bits
  wire logic e_berr = ((hs_r == HS_LOW) | (hs_r == HS_HIGH)) &
                      (start_det | stop_det);
  // Value to place on SDA for this bit, 1 meaning released
  wire logic bit_out = (bit_r == 4'h8) ? (acko_r ? ack_action_bit_r : 1'b1) :
                       (rd_r ? 1'b1 : sh_r[7]);
  // Bits whose level we own and must see on the wire
  wire logic mine = (bit_r == 4'h8) ? acko_r : ~rd_r;
  wire logic half_up = cnt_r == HALF_M1;

  // Next state of the host engine
  always_comb begin
    hs_nxt = hs_r;
    cnt_nxt = cnt_r + 16'h0001;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    sda_lo_nxt = sda_lo_r;
    rd_nxt = rd_r;
    isad_nxt = isad_r;
    acko_nxt = acko_r;
    ph_nxt = ph_r;
    gost_nxt = gost_r;
    pend_nxt = pend_r;
    pcmd_nxt = pcmd_r;
    {e_wack, e_rack, e_nack, e_dtx, e_rif, e_lose, e_own} = 7'h00;
    case (hs_r)
      HS_IDLE: begin
        sda_lo_nxt = 1'b0;
        if (w_hadr) begin // R22
          pend_nxt = 1'b1;
          sh_nxt = pwdata[7:0];
        end
        // Waits while the bus is not Idle
        if (pend_r && host_en && bus_r == BS_IDLE) begin // R22
          hs_nxt = HS_START;
          cnt_nxt = 16'h0000;
          sda_lo_nxt = 1'b1;
          pend_nxt = 1'b0;
          e_own = 1'b1;
        end
      end
      HS_START: begin
        if (half_up) begin
          hs_nxt = HS_LOW;
          cnt_nxt = 16'h0000;
          bit_nxt = 4'h0;
          sh_nxt = haddr_r;
          {isad_nxt, rd_nxt, acko_nxt} = 3'h4;
        end
      end
      HS_LOW: begin
        // SDA moves mid-low so the synced SCL is surely low
        if (cnt_r == QTR) sda_lo_nxt = ~bit_out; // R13
        if (half_up) begin
          hs_nxt = HS_HIGH;
          cnt_nxt = 16'h0000;
        end
      end
      HS_HIGH: begin
        // Timer waits for SCL high, so clients may stretch it
        if (!scl_s) cnt_nxt = 16'h0000;
        else if (half_up) begin
          cnt_nxt = 16'h0000;
          hs_nxt = HS_LOW;
          if (mine && !sda_lo_r && !sda_s) begin // R9 R14
            e_lose = 1'b1;
          end else if (bit_r == 4'h8 && acko_r) begin
            acko_nxt = 1'b0;
            case (pcmd_r)
              CMD_RECV: begin
                bit_nxt = 4'h0;
                rd_nxt = 1'b1;
              end
              CMD_STOP: begin
                hs_nxt = HS_STOP;
                {ph_nxt, gost_nxt} = 2'h0;
              end
              CMD_REPSTART: begin
                hs_nxt = HS_STOP;
                {ph_nxt, gost_nxt} = 2'h1;
              end
              default: hs_nxt = HS_HOLD;
            endcase
          end else if (bit_r == 4'h8) begin
            hs_nxt = HS_HOLD;
            if (!isad_r) e_dtx = 1'b1; // R8 R10
            else if (sda_s) e_nack = 1'b1; // R4
            else if (!haddr_r[0]) e_wack = 1'b1; // R1
            else begin
              // Client drives data at once
              e_rack = 1'b1; // R3
              hs_nxt = HS_LOW;
              {bit_nxt, rd_nxt, isad_nxt} = {4'h0, 2'h2};
            end
          end else begin
            sh_nxt = {sh_r[6:0], sda_s};
            bit_nxt = bit_r + 4'h1;
            if (rd_r && bit_r == 4'h7) begin
              e_rif = 1'b1; // R12
              hs_nxt = HS_HOLD;
            end
          end
        end
      end
      HS_HOLD: begin
        cnt_nxt = 16'h0000;
        if (cmd_go && rd_r) begin
          // Ack slot first, then the command itself
          hs_nxt = HS_LOW;
          {bit_nxt, acko_nxt} = {4'h8, 1'b1}; // R13
          pcmd_nxt = cmd_w;
        end else if (cmd_go && cmd_w != CMD_RECV) begin // R5
          hs_nxt = HS_STOP;
          ph_nxt = 1'b0;
          gost_nxt = cmd_w == CMD_REPSTART;
        end else if (w_hdat && !rd_r) begin // R8
          hs_nxt = HS_LOW;
          {bit_nxt, isad_nxt} = {4'h0, 1'b0};
          sh_nxt = pwdata[7:0];
        end else if (w_hadr) begin // R22
          hs_nxt = HS_STOP;
          {ph_nxt, gost_nxt} = 2'h1;
          sh_nxt = pwdata[7:0];
        end
      end
      HS_STOP: begin
        // Phase 0 with SCL low, phase 1 with SCL released
        if (!ph_r && cnt_r == QTR) sda_lo_nxt = ~gost_r;
        if (ph_r && !scl_s) cnt_nxt = 16'h0000;
        else if (half_up) begin
          cnt_nxt = 16'h0000;
          ph_nxt = 1'b1;
          if (ph_r) begin
            hs_nxt = gost_r ? HS_START : HS_IDLE;
            sda_lo_nxt = gost_r;
          end
        end
      end
      default: hs_nxt = HS_IDLE;
    endcase
    // Loss drops SDA and SCL at once
    if (e_lose || e_berr || !host_en) begin // R6 R7
      hs_nxt = HS_IDLE;
      sda_lo_nxt = 1'b0;
      pend_nxt = 1'b0;
    end
  end

  // Host engine registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hs_r <= HS_IDLE;
      {cnt_r, bit_r, sh_r} <= 28'h0000000;
      {sda_lo_r, rd_r, isad_r, acko_r, ph_r, gost_r, pend_r} <= 7'h00;
      pcmd_r <= CMD_NOACT;
    end else begin
      hs_r <= hs_nxt;
      {cnt_r, bit_r, sh_r} <= {cnt_nxt, bit_nxt, sh_nxt};
      {sda_lo_r, rd_r, isad_r} <= {sda_lo_nxt, rd_nxt, isad_nxt};
      {acko_r, ph_r, gost_r, pend_r} <= {acko_nxt, ph_nxt, gost_nxt,
                                         pend_nxt};
      pcmd_r <= pcmd_nxt;
    end
  end

  // ============================================================
  // Host status flags; a hardware set beats a software clear
  wire logic lose = e_lose | e_berr;
  wire logic hold_go = (hs_r == HS_HOLD) & (hs_nxt != HS_HOLD);
  wire logic set_wif = e_wack | e_nack | e_dtx | lose;
  wire logic set_hold = e_wack | e_nack | e_dtx | e_rif;
  wire logic clr_hold = clr_wif | clr_rif | hold_go | lose;
  wire logic wif_nxt = (hf_r.host_write_flag & ~(clr_wif | hold_go | e_rif)) |
                       set_wif; // R15
  wire logic rif_nxt = (hf_r.host_read_flag & ~(clr_rif | hold_go | set_wif)) |
                       e_rif; // R15
  wire logic received_ack_flag_nxt = e_nack ? 1'b1 : e_dtx ? sda_s :
                         (e_wack | e_rack) ? 1'b0 : hf_r.received_ack_flag; // R10
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hf_r <= '0;
    end else begin
      hf_r.host_write_flag <= wif_nxt; // R1 R4 R6
      hf_r.host_read_flag <= rif_nxt; // R12
      hf_r.hold <= (hf_r.hold & ~clr_hold) | set_hold; // R23
      hf_r.received_ack_flag <= received_ack_flag_nxt; // R1 R3
      hf_r.arb <= (hf_r.arb & ~clr_arb) | lose; // R6
      hf_r.berr <= (hf_r.berr & ~clr_berr) | e_berr; // R7
    end
  end

  // ============================================================
  // Bus state tracking
  always_ff @(posedge ref_clk) begin
    if (!rst_n) bus_r <= BS_UNKNOWN;
    else if (!host_en) bus_r <= BS_UNKNOWN; // R21
    else if (force_idle) bus_r <= BS_IDLE; // R21
    else if (lose) bus_r <= BS_BUSY; // R6
    else if (e_own) bus_r <= BS_OWNER;
    else if (stop_det) bus_r <= BS_IDLE;
    else if (start_det && bus_r == BS_IDLE) bus_r <= BS_BUSY;
  end

  // ============================================================
  // Client address recognition
  logic c_act, c_fresh, c_pend, c_ack, chold, address_or_stop_flag, ap, dir, cberr;
  logic [2:0] c_cnt;
  logic [7:0] c_sh;
  wire logic [7:0] c_rx = {c_sh[6:0], sda_s};
  wire logic c_match = ctrl_r[`IHCS_PROM_BIT] |
                       (c_rx[7:1] == caddr_r[7:1]) |
                       ((c_rx[7:1] == 7'h00) & caddr_r[0]) |
                       (cmask_r[0] & (c_rx[7:1] == cmask_r[7:1])); // R18
  wire logic c_last = c_act & scl_rise & (c_cnt == 3'h7);
  wire logic c_set = c_last & c_match;
  wire logic c_clr = w_cst & pwdata[`IHCS_ADDRESS_OR_STOP_FLAG_BIT];
  // Shift address bits on SCL rise, ack on the following low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {c_act, c_fresh, c_pend, c_ack, chold} <= 5'h00;
      {c_cnt, c_sh, cdata_r} <= 19'h00000;
    end else if (!cli_en) begin
      {c_act, c_pend, c_ack, chold} <= 4'h0;
    end else begin
      if (start_det) begin
        {c_act, c_fresh, c_cnt} <= {2'h3, 3'h0};
      end else if (stop_det) begin
        c_act <= 1'b0;
      end else if (c_act && scl_rise) begin
        c_sh <= c_rx;
        c_cnt <= c_cnt + 3'h1;
        c_fresh <= 1'b0;
        // A miss waits for the next start
        if (c_cnt == 3'h7) c_act <= 1'b0; // R17
      end
      if (c_set) cdata_r <= c_rx; // R17
      if (c_set) c_pend <= 1'b1;
      else if (c_pend && scl_fall) {c_pend, c_ack} <= 2'h1; // R17
      else if (c_ack && scl_fall) {c_ack, chold} <= 2'h1; // R16 R20
      else if (!address_or_stop_flag) chold <= 1'b0;
    end
  end
  // Client flags; set beats clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {address_or_stop_flag, ap, dir, cberr} <= 4'h0;
    end else begin
      address_or_stop_flag <= (address_or_stop_flag & ~c_clr) | c_set; // R18
      if (c_set) {ap, dir} <= {1'b1, c_rx[0]}; // R20
      cberr <= (cberr & ~(w_cst & pwdata[`IHCS_CBERR_BIT])) |
               (cli_en & stop_det & c_act & c_fresh); // R19
    end
  end

  // ============================================================
  // Control registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_r <= `IHCS_CTRL_RST;
      ack_action_bit_r <= 1'b0;
      {haddr_r, caddr_r, cmask_r} <= {3{`IHCS_BYTE_RST}};
    end else begin
      if (wr && s_ctrl) ctrl_r <= pwdata[2:0];
      if (w_hcmd) ack_action_bit_r <= pwdata[`IHCS_ACK_ACTION_BIT_BIT]; // R13
      if (w_hadr) haddr_r <= pwdata[7:0]; // R22
      if (wr && s_cadr) caddr_r <= pwdata[7:0];
      if (wr && s_cmsk) cmask_r <= pwdata[7:0];
    end
  end

  // ============================================================
  // Read mux, captured in the setup cycle
  wire logic [31:0] hst_word = {24'h000000, hf_r.host_read_flag, hf_r.host_write_flag, hf_r.hold,
                                hf_r.received_ack_flag, hf_r.arb, hf_r.berr, bus_r};
  wire logic [31:0] cst_word = {25'h0000000, address_or_stop_flag, chold, 2'h0, cberr,
                                dir, ap};
  wire logic [31:0] rd_mux =
    s_ctrl ? {29'h00000000, ctrl_r} :
    s_hcmd ? {29'h00000000, ack_action_bit_r, pcmd_r} :
    s_hst ? hst_word : // R21
    s_hadr ? {24'h000000, haddr_r} :
    s_hdat ? {24'h000000, sh_r} :
    s_cadr ? {24'h000000, caddr_r} :
    s_cmsk ? {24'h000000, cmask_r} :
    s_cst ? cst_word :
    s_cdat ? {24'h000000, cdata_r} : 32'h00000000;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) prdata_r <= 32'h00000000;
    else if (psel && !penable) prdata_r <= rd_mux;
  end

  // ============================================================
  // Outputs: both lines open drain
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = (hs_r == HS_LOW) | ((hs_r == HS_STOP) & ~ph_r) |
                  ((hs_r == HS_HOLD) & hf_r.hold) | (chold & address_or_stop_flag); // R2 R16
  assign sda_oe = sda_lo_r | c_ack; // R17

  // ============================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_ack_slot;
    c_pend && scl_fall && cli_en;
  endsequence
  sequence s_data_go;
    hs_r == HS_HOLD && !rd_r && w_hdat && !cmd_go;
  endsequence
  chk_flags_exclusive: assert property (!(hf_r.host_read_flag && hf_r.host_write_flag)) // R15
    else $error("read and write flags both set");
  chk_write_addr_ack: assert property (e_wack |=> hf_r.host_write_flag && // R1
    !hf_r.received_ack_flag && hf_r.hold && hs_r == HS_HOLD)
    else $error("write address ack flags wrong");
  chk_hold_scl_low: assert property (hs_r == HS_HOLD && hf_r.hold // R2
    |-> scl_oe) else $error("clock hold not driving SCL");
  chk_nack_flags: assert property (e_nack |=> hf_r.host_write_flag && // R4
    hf_r.received_ack_flag) else $error("refused address flags wrong");
  chk_arb_release: assert property (e_lose |=> bus_r == BS_BUSY && // R6
    hf_r.arb && hf_r.host_write_flag && !sda_lo_r ##1 hs_r == HS_IDLE)
    else $error("arbitration loss not handled");
  chk_berr_flags: assert property (e_berr |=> hf_r.berr && // R7
    hf_r.arb && hf_r.host_write_flag) else $error("bus error flags wrong");
  chk_data_start: assert property (s_data_go |=> !hf_r.host_write_flag && // R8
    hs_r == HS_LOW && bit_r == 4'h0) else $error("data write misfired");
  chk_read_hold: assert property (e_rif |=> hf_r.host_read_flag && // R12
    hf_r.hold && scl_oe) else $error("read byte hold missing");
  chk_ack_value: assert property (hs_r == HS_HIGH && acko_r && // R13
    bit_r == 4'h8 && cnt_r > QTR |-> sda_lo_r == ~ack_action_bit_r)
    else $error("ack slot level wrong");
  chk_client_ack: assert property (s_ack_slot |=> c_ack && // R17
    sda_oe) else $error("client did not ack");
  chk_client_hold: assert property (chold && address_or_stop_flag |-> scl_oe) // R16
    else $error("client flag without SCL hold");
  chk_start_stop: assert property (stop_det && c_act && c_fresh && // R19
    cli_en |=> cberr) else $error("start-stop not flagged");
  chk_idle_force: assert property (force_idle && host_en |=> // R21
    bus_r == BS_IDLE) else $error("bus state not forced idle");
endmodule // ihcs_top
`default_nettype wire

// *** rtl/ihcs_map.svh ***
/*
  Register map, field positions, reset values and timing counts of the
  two-wire host/client status block.
  Assumes a 200 MHz core clock and a 32-bit APB register bus.
*/
`ifndef IHCS_MAP_SVH
`define IHCS_MAP_SVH
// ============================================================
// Register byte offsets
`define IHCS_CTRL_OFS 8'h00
`define IHCS_HCMD_OFS 8'h04
`define IHCS_HSTAT_OFS 8'h08
`define IHCS_HADDR_OFS 8'h0C
`define IHCS_HDATA_OFS 8'h10
`define IHCS_CADDR_OFS 8'h14
`define IHCS_CMASK_OFS 8'h18
`define IHCS_CSTAT_OFS 8'h1C
`define IHCS_CDATA_OFS 8'h20
// ============================================================
// Field positions
`define IHCS_HEN_BIT 0
`define IHCS_CEN_BIT 1
`define IHCS_PROM_BIT 2
`define IHCS_ACK_ACTION_BIT_BIT 2
`define IHCS_RIF_BIT 7
`define IHCS_WIF_BIT 6
`define IHCS_HOLD_BIT 5
`define IHCS_RECEIVED_ACK_FLAG_BIT 4
`define IHCS_ARB_BIT 3
`define IHCS_BERR_BIT 2
`define IHCS_ADDRESS_OR_STOP_FLAG_BIT 6
`define IHCS_CHOLD_BIT 5
`define IHCS_CBERR_BIT 2
`define IHCS_DIR_BIT 1
`define IHCS_AP_BIT 0
// ============================================================
// Reset values
`define IHCS_CTRL_RST 3'h0
`define IHCS_BYTE_RST 8'h00
// ============================================================
// Timing: half of one bus clock period
`define IHCS_CLK_NS 5
`define IHCS_HALF_NS 1250
`define IHCS_HALF_CYC ((`IHCS_HALF_NS + `IHCS_CLK_NS - 1) / `IHCS_CLK_NS)
`endif

// *** rtl/ihcs_pkg.sv ***
/*
  Types of the two-wire host/client status block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ihcs_pkg;
  // Host engine states, one-hot
  typedef enum logic [5:0] {
    HS_IDLE = 6'h01, HS_START = 6'h02, HS_LOW = 6'h04,
    HS_HIGH = 6'h08, HS_HOLD = 6'h10, HS_STOP = 6'h20
  } ihcs_hs_e;
  // Bus state as software sees it
  typedef enum logic [1:0] {
    BS_UNKNOWN = 2'h0, BS_IDLE = 2'h1, BS_OWNER = 2'h2, BS_BUSY = 2'h3
  } ihcs_bus_e;
  // Host commands
  typedef enum logic [1:0] {
    CMD_NOACT = 2'h0, CMD_REPSTART = 2'h1, CMD_RECV = 2'h2, CMD_STOP = 2'h3
  } ihcs_cmd_e;
  // Host status flags
  typedef struct packed {
    logic host_read_flag;
    logic host_write_flag;
    logic hold;
    logic received_ack_flag;
    logic arb;
    logic berr;
  } ihcs_hflags_s;
endpackage

// *** sim/ihcs_client_model.sv ***
/* Behavioural client on the far side of the two-wire bus.
   Assumes resolved lines with pull-ups, sampled on the core clock. */
`timescale 1ns/1ps
`default_nettype none
module ihcs_client_model (
  // Clock
  input wire logic clk,
  // Resolved lines
  input wire logic scl,
  input wire logic sda,
  // Behaviour controls
  input wire logic ack_en,
  input wire logic collide,
  input wire logic [7:0] tx_byte,
  // High pulls SDA low
  output logic sda_oe
);
  logic scl_q = 1'b1, sda_q = 1'b1, rd = 1'b0, first = 1'b0, col_q = 1'b0;
  logic [3:0] bitc = 4'h0; // Bits seen in the frame
  logic [7:0] rx = 8'h00; // Shifted-in byte
  initial sda_oe = 1'b0;
  // ==========================================
  // Frame tracking on line edges
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    col_q <= collide;
    if (col_q && !collide) begin
      sda_oe <= 1'b0; // Let go while SCL high, seen as a Stop
    end else if (scl && scl_q && sda_q && !sda) begin
      bitc <= 4'h0; // Start
      first <= 1'b1;
      rd <= 1'b0;
      sda_oe <= 1'b0;
    end else if (scl && scl_q && !sda_q && sda) begin
      bitc <= 4'h0; // Stop
      rd <= 1'b0;
    end else if (scl && !scl_q) begin
      if (bitc < 4'h8) rx <= {rx[6:0], sda};
      if (bitc == 4'h8 && sda && !first) rd <= 1'b0; // Host refused more
      bitc <= bitc + 4'h1;
    end else if (!scl && scl_q) begin
      if (bitc == 4'h8) begin
        sda_oe <= (rd && !first) ? 1'b0 : ack_en; // Own ack slot
        if (first) rd <= rx[0];
      end else if (bitc == 4'h9) begin
        bitc <= 4'h0;
        first <= 1'b0;
        sda_oe <= rd & ~tx_byte[7];
      end else if (rd) begin
        sda_oe <= ~tx_byte[3'h7 - bitc[2:0]];
      end else begin
        sda_oe <= collide; // Only a commanded collision pulls low
      end
    end
  end
endmodule // ihcs_client_model
`default_nettype wire

// *** sim/tb.sv ***
/* Self-checking bench of the host/client status block.
   Assumes the APB map header and the client model beside it. */
`timescale 1ns/1ps
`default_nettype none
`include "ihcs_map.svh"
module tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ack_en = 1'b1, collide = 1'b0, err;
  logic [7:0] paddr = 8'h00, tx_byte = 8'h5A;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, p_sda_oe;
  wire logic scl_w = ~scl_oe; // Pull-up unless pulled low
  wire logic sda_w = ~(sda_oe | p_sda_oe);
  int errors = 0, num_checks = 0;
  ihcs_top #(.HALF_CYC(12)) i_ihcs_top (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe));
  ihcs_client_model i_ihcs_client_model (.clk(ref_clk), .scl(scl_w),
    .sda(sda_w), .ack_en(ack_en), .collide(collide), .tx_byte(tx_byte),
    .sda_oe(p_sda_oe));
  initial forever #2.5 ref_clk = ~ref_clk;
  // ==========================================
  // Verdict and comparison
  task summarize;
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ==========================================
  // APB cycle; held until pready seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      errors++;
      summarize();
    end
  endtask
  task st(input string nm, input logic [7:0] e);
    apb(1'b0, `IHCS_HSTAT_OFS, 32'h0);
    chk(nm, {24'h0, e}, q);
  endtask
  // Polls status; a poll per few cycles keeps the bound short
  task wt(input logic [7:0] m, input logic [7:0] v);
    int n;
    for (n = 0; n < 400; n++) begin
      apb(1'b0, `IHCS_HSTAT_OFS, 32'h0);
      if ((q[7:0] & m) === v) break;
    end
    if (n == 400) begin
      errors++;
      summarize();
    end
  endtask
  task addr(input logic [7:0] a);
    apb(1'b1, `IHCS_HADDR_OFS, {24'h0, a});
  endtask
  task to_idle; // Stop command, then Idle
    apb(1'b1, `IHCS_HCMD_OFS, 32'h3);
    wt(8'h03, 8'h01);
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
    st("reset status", 8'h00);
    chk("scl_oe", 0, scl_oe);
    chk("scl_out", 0, scl_out);
    chk("sda_out", 0, sda_out);
    apb(1'b1, 8'h40, 32'h5);
    chk("slverr", 1, err);
    apb(1'b1, `IHCS_CTRL_OFS, 32'h1);
    apb(1'b1, `IHCS_HSTAT_OFS, 32'h1);
    st("forced idle", 8'h01);
  endtask
  task t_write;
    addr(8'hA4);
    wt(8'h40, 8'h40);
    st("write ack", 8'h62);
    apb(1'b0, `IHCS_HDATA_OFS, 32'h0);
    chk("copy", 32'hA4, q);
    repeat (100) @(posedge ref_clk);
    chk("scl held", 0, scl_w);
    ack_en <= 1'b0;
    apb(1'b1, `IHCS_HDATA_OFS, 32'h3C);
    apb(1'b0, `IHCS_HSTAT_OFS, 32'h0);
    chk("wif cleared", 0, q[6]);
    wt(8'h40, 8'h40);
    st("data nack", 8'h72);
    to_idle();
  endtask
  task t_nack;
    addr(8'hA4);
    wt(8'h40, 8'h40);
    st("no ack", 8'h72);
    to_idle();
  endtask
  task t_read;
    ack_en <= 1'b1;
    addr(8'hA5);
    wt(8'h80, 8'h80);
    st("read byte", 8'hA2);
    apb(1'b0, `IHCS_HDATA_OFS, 32'h0);
    chk("rx data", 32'h5A, q);
    apb(1'b1, `IHCS_HCMD_OFS, 32'h7);
    wt(8'h03, 8'h01);
  endtask
  task t_arb;
    collide <= 1'b1;
    addr(8'hA4);
    wt(8'h08, 8'h08);
    st("arb lost", 8'h4B);
    chk("sda released", 0, sda_oe);
    chk("scl released", 0, scl_oe);
    collide <= 1'b0;
    wt(8'h03, 8'h01);
    apb(1'b1, `IHCS_HSTAT_OFS, 32'hCC);
    st("flags cleared", 8'h01);
  endtask
  task t_client;
    apb(1'b1, `IHCS_CADDR_OFS, 32'hA4);
    apb(1'b1, `IHCS_CTRL_OFS, 32'h3);
    ack_en <= 1'b0;
    addr(8'hA4);
    wt(8'h40, 8'h40);
    apb(1'b0, `IHCS_CSTAT_OFS, 32'h0);
    chk("addr flag", 1, q[6]);
    chk("direction", 0, q[1]);
    apb(1'b0, `IHCS_CDATA_OFS, 32'h0);
    chk("stored addr", 32'hA4, q);
    chk("client hold", 0, scl_w);
    apb(1'b1, `IHCS_CSTAT_OFS, 32'h40);
    apb(1'b1, `IHCS_CTRL_OFS, 32'h1);
    to_idle();
  endtask
  task t_hold;
    ack_en <= 1'b1;
    addr(8'hA4);
    wt(8'h40, 8'h40);
    apb(1'b1, `IHCS_HSTAT_OFS, 32'h40);
    st("hold released", 8'h02);
    repeat (20) @(posedge ref_clk);
    chk("scl free", 0, scl_oe);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_write();
    t_nack();
    t_read();
    t_arb();
    t_client();
    t_hold();
    summarize();
  end
endmodule // tb
`default_nettype wire
